// ### bpsd_pkg.sv
// Package of constants and types for the bridge PWM shutdown and dead-band stage.
package bpsd_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [3:0] BPSD_OFS_CTRL     = 4'h0;
  localparam logic [3:0] BPSD_OFS_SHUTDOWN = 4'h4;
  localparam logic [3:0] BPSD_OFS_DEADBAND = 4'h8;
  localparam logic [3:0] BPSD_OFS_STATUS   = 4'hC;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BPSD_CTRL_MODE_LSB = 0;
  localparam int BPSD_CTRL_POL_AC   = 2;
  localparam int BPSD_CTRL_POL_BD   = 3;
  localparam int BPSD_CTRL_ENABLE   = 4;
  localparam int BPSD_SD_BD_LSB     = 0;
  localparam int BPSD_SD_AC_LSB     = 2;
  localparam int BPSD_SD_SRC_LSB    = 4;
  localparam int BPSD_SD_STATUS     = 7;
  localparam int BPSD_DB_COUNT_LSB  = 0;
  localparam int BPSD_DB_RESTART    = 7;

  // ****************************************************************
  // Encodings and reset values
  // ****************************************************************
  localparam logic [1:0] BPSD_MODE_SINGLE   = 2'h0;
  localparam logic [1:0] BPSD_MODE_FULL_FWD = 2'h1;
  localparam logic [1:0] BPSD_MODE_HALF     = 2'h2;
  localparam logic [1:0] BPSD_MODE_FULL_REV = 2'h3;
  localparam logic [1:0] BPSD_SAFE_LOW      = 2'h0;
  localparam logic [1:0] BPSD_SAFE_HIGH     = 2'h1;
  localparam logic [2:0] BPSD_SRC_COMP_A    = 3'h1;
  localparam logic [2:0] BPSD_SRC_COMP_B    = 3'h2;
  localparam logic [2:0] BPSD_SRC_INT_PIN   = 3'h4;
  localparam logic [7:0] BPSD_RST_CTRL      = 8'h00;
  localparam logic [7:0] BPSD_RST_SHUTDOWN  = 8'h00;
  localparam logic [7:0] BPSD_RST_DEADBAND  = 8'h00;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int         BPSD_DIR_LEAD_COUNTS = 4;
  localparam int         BPSD_OSC_PER_INSTR   = 4;
  localparam int         BPSD_DB_CNT_W        = 9;
  localparam logic [7:0] BPSD_DIR_LEAD_M1     = 8'(BPSD_DIR_LEAD_COUNTS - 1);

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [0:0] {BPSD_RUN, BPSD_BLANK} bpsd_phase_t;

endpackage

// ### bpsd_bridge_pwm.sv
// Bridge PWM output stage with direction change, auto-shutdown and dead-band.
//
// Decided for this implementation: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Forward: A active, D modulated, B C inactive.
// - Reverse: C active, B modulated, A D inactive.
// - New direction takes effect from next PWM cycle.
// - Four counts early: blank B D, swap A C.
// - Newly modulated output resumes at next period start.
// - No dead-band in full-bridge mode.
// - Three-bit shutdown source select field.
// - Status bit one means outputs shut down.
// - Shutdown sets status until software or restart clears.
// - Shutdown forces enabled pins to safe levels immediately.
// - Pairs AC and BD take own safe state.
// - Shutdown is level sensitive while source asserted.
// - Status writes ignored while source asserted.
// - Output resumes only at next period start.
// - Auto-restart enable bit; clear otherwise software only.
// - Auto-restart clears status once source deasserts.
// - Dead-band delays only inactive-to-active edges.
// - Dead-band is low seven bits, instruction cycles.
// - Mode field: 00 single, 10 half, 01/11 full.
// - Half-bridge: PWM on A, complement on B.
// - Dead-band longer than active keeps output inactive.
module bpsd_bridge_pwm
  import bpsd_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        pwm_in,
  input  wire logic        period_start,
  input  wire logic [7:0]  period_timer_count,
  input  wire logic [7:0]  period_limit,
  input  wire logic        ext_int_n,
  input  wire logic        comp_a,
  input  wire logic        comp_b,
  output logic             bridge_out_a,
  output logic             bridge_out_a_oe,
  output logic             bridge_out_b,
  output logic             bridge_out_b_oe,
  output logic             bridge_out_c,
  output logic             bridge_out_c_oe,
  output logic             bridge_out_d,
  output logic             bridge_out_d_oe
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [31:0]                 rdata;
    logic                        ready;
    logic                        wr_pend;
    logic [3:0]                  wr_ofs;
    logic [1:0]                  output_mode_field;
    logic                        pol_ac;
    logic                        pol_bd;
    logic                        enable;
    logic [2:0]                  shutdown_source_sel;
    logic                        shutdown_event_status;
    logic [1:0]                  pair_ac_safe_state;
    logic [1:0]                  pair_bd_safe_state;
    logic                        auto_restart_enable;
    logic [6:0]                  deadband_count;
    logic                        dir;
    bpsd_phase_t                 phase;
    logic                        wait_start;
    logic [1:0]                  db_req;
    logic [1:0][BPSD_DB_CNT_W-1:0] db_cnt;
    logic [3:0]                  pin;
    logic [3:0]                  oe;
  } bpsd_state_t;

  bpsd_state_t s_q;
  bpsd_state_t s_d;

  logic [7:0] ctrl_rd;
  logic [7:0] shutdown_rd;
  logic [7:0] deadband_rd;
  logic [7:0] status_rd;
  logic       src_active;
  logic       full_bridge;
  logic       half_bridge;
  logic       lead_point;
  logic [1:0] db_raw;
  logic [1:0] db_gate;
  logic [3:0] act;
  logic [3:0] used;
  logic [1:0] safe_sel;

  assign ctrl_rd     = {3'h0, s_q.enable, s_q.pol_bd, s_q.pol_ac, s_q.output_mode_field};
  assign shutdown_rd = {s_q.shutdown_event_status, s_q.shutdown_source_sel,
                        s_q.pair_ac_safe_state, s_q.pair_bd_safe_state};
  assign deadband_rd = {s_q.auto_restart_enable, s_q.deadband_count};
  assign status_rd   = {s_q.pin, s_q.wait_start, (s_q.phase == BPSD_BLANK), s_q.dir,
                        src_active};

  // Level-sensitive source decode; each set bit of the field adds a source.
  assign src_active = ((s_q.shutdown_source_sel & BPSD_SRC_COMP_A) != 3'h0 && comp_a)
                   || ((s_q.shutdown_source_sel & BPSD_SRC_COMP_B) != 3'h0 && comp_b)
                   || ((s_q.shutdown_source_sel & BPSD_SRC_INT_PIN) != 3'h0 && !ext_int_n);

  assign full_bridge = s_q.output_mode_field[0];
  assign half_bridge = (s_q.output_mode_field == BPSD_MODE_HALF);
  assign lead_point  = (period_timer_count + BPSD_DIR_LEAD_M1 == period_limit);

  // ****************************************************************
  // Dead-band requests per half-bridge output
  // ****************************************************************
  assign db_raw = {!pwm_in, pwm_in};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_db
      // Released only when the request stands and its counter has run out.
      assign db_gate[gi] = db_raw[gi] && !(db_raw[gi] && !s_q.db_req[gi])
                           && (s_q.db_cnt[gi] == '0);
    end
  endgenerate

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb
  begin
    s_d = s_q;
    act = 4'h0;
    used = 4'h0;
    safe_sel = 2'h0;

    // Bus slave: zero wait states, always OKAY.
    s_d.ready = 1'b1;
    s_d.wr_pend = 1'b0;
    s_d.rdata = 32'h0000_0000;
    if (hsel && hready && htrans[1])
    begin
      s_d.wr_pend = hwrite;
      s_d.wr_ofs = haddr[3:0];
      if (!hwrite && haddr[31:4] == 28'h000_0000)
      begin
        unique case (haddr[3:0])
          BPSD_OFS_CTRL:     s_d.rdata = {24'h00_0000, ctrl_rd};
          BPSD_OFS_SHUTDOWN: s_d.rdata = {24'h00_0000, shutdown_rd};
          BPSD_OFS_DEADBAND: s_d.rdata = {24'h00_0000, deadband_rd};
          BPSD_OFS_STATUS:   s_d.rdata = {24'h00_0000, status_rd};
          default:           s_d.rdata = 32'h0000_0000;
        endcase
      end
      else
      begin
        s_d.wr_pend = hwrite && (haddr[31:4] == 28'h000_0000);
      end
    end

    if (s_q.wr_pend)
    begin
      unique case (s_q.wr_ofs)
        BPSD_OFS_CTRL:
        begin
          s_d.output_mode_field = hwdata[BPSD_CTRL_MODE_LSB +: 2];
          s_d.pol_ac = hwdata[BPSD_CTRL_POL_AC];
          s_d.pol_bd = hwdata[BPSD_CTRL_POL_BD];
          s_d.enable = hwdata[BPSD_CTRL_ENABLE];
          if (hwdata[BPSD_CTRL_ENABLE] && !s_q.enable)
          begin
            s_d.wait_start = 1'b1;
          end
        end
        BPSD_OFS_SHUTDOWN:
        begin
          s_d.shutdown_source_sel = hwdata[BPSD_SD_SRC_LSB +: 3];
          s_d.pair_ac_safe_state = hwdata[BPSD_SD_AC_LSB +: 2];
          s_d.pair_bd_safe_state = hwdata[BPSD_SD_BD_LSB +: 2];
          if (!src_active)
          begin
            s_d.shutdown_event_status = hwdata[BPSD_SD_STATUS];
          end
        end
        BPSD_OFS_DEADBAND:
        begin
          s_d.auto_restart_enable = hwdata[BPSD_DB_RESTART];
          s_d.deadband_count = hwdata[BPSD_DB_COUNT_LSB +: 7];
        end
        default:
        begin
          s_d.wait_start = s_d.wait_start;
        end
      endcase
    end

    // Shutdown status: the source sets it and wins over any clear.
    if (s_q.auto_restart_enable && !src_active)
    begin
      s_d.shutdown_event_status = 1'b0;
    end
    if (src_active)
    begin
      s_d.shutdown_event_status = 1'b1;
    end
    if (s_q.shutdown_event_status && !s_d.shutdown_event_status)
    begin
      s_d.wait_start = 1'b1;
    end
    else if (period_start)
    begin
      s_d.wait_start = 1'b0;
    end

    // Direction tracking and the blanking window around a reversal.
    if (!full_bridge)
    begin
      s_d.dir = s_d.output_mode_field[1];
      s_d.phase = BPSD_RUN;
    end
    else if (s_q.output_mode_field[1] != s_q.dir && lead_point)
    begin
      s_d.dir = s_q.output_mode_field[1];
      s_d.phase = BPSD_BLANK;
    end
    else if (s_q.phase == BPSD_BLANK && period_start)
    begin
      s_d.phase = BPSD_RUN;
    end

    // Dead-band down-counters, reloaded on each new request.
    for (int i = 0; i < 2; i++)
    begin
      s_d.db_req[i] = db_raw[i];
      if (db_raw[i] && !s_q.db_req[i])
      begin
        s_d.db_cnt[i] = BPSD_DB_CNT_W'({2'h0, s_q.deadband_count} * BPSD_OSC_PER_INSTR);
      end
      else if (s_q.db_cnt[i] != '0)
      begin
        s_d.db_cnt[i] = s_q.db_cnt[i] - BPSD_DB_CNT_W'(1);
      end
    end

    // Logical active pattern per pin, index 0 to 3 is A to D.
    unique case (s_q.output_mode_field)
      BPSD_MODE_SINGLE:
      begin
        act[0] = pwm_in;
        used = 4'h1;
      end
      BPSD_MODE_HALF:
      begin
        act[1:0] = db_gate;
        used = 4'h3;
      end
      default:
      begin
        used = 4'hF;
        if (!s_d.dir)
        begin
          act[0] = 1'b1;
          act[3] = pwm_in && (s_d.phase == BPSD_RUN);
        end
        else
        begin
          act[2] = 1'b1;
          act[1] = pwm_in && (s_d.phase == BPSD_RUN);
        end
      end
    endcase
    if (s_q.wait_start || s_d.wait_start)
    begin
      act = 4'h0;
    end

    // Pins: polarity per pair, then shutdown override per pair.
    for (int p = 0; p < 4; p++)
    begin
      s_d.pin[p] = act[p] ^ (p[0] ? s_q.pol_bd : s_q.pol_ac);
      s_d.oe[p] = s_q.enable && used[p];
      if (s_d.shutdown_event_status)
      begin
        safe_sel = p[0] ? s_q.pair_bd_safe_state : s_q.pair_ac_safe_state;
        s_d.pin[p] = (safe_sel == BPSD_SAFE_HIGH);
        s_d.oe[p] = s_d.oe[p] && !safe_sel[1];
      end
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      s_q <= '0;
      s_q.output_mode_field <= BPSD_RST_CTRL[1:0];
      s_q.shutdown_event_status <= BPSD_RST_SHUTDOWN[BPSD_SD_STATUS];
      s_q.auto_restart_enable <= BPSD_RST_DEADBAND[BPSD_DB_RESTART];
      s_q.phase <= BPSD_RUN;
      s_q.ready <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign hrdata = s_q.rdata;
  assign hreadyout = s_q.ready;
  assign hresp = 1'b0;
  assign bridge_out_a = s_q.pin[0];
  assign bridge_out_a_oe = s_q.oe[0];
  assign bridge_out_b = s_q.pin[1];
  assign bridge_out_b_oe = s_q.oe[1];
  assign bridge_out_c = s_q.pin[2];
  assign bridge_out_c_oe = s_q.oe[2];
  assign bridge_out_d = s_q.pin[3];
  assign bridge_out_d_oe = s_q.oe[3];

endmodule
`default_nettype wire

// ### bpsd_bridge_pwm_props.sv
// Checker of the bridge PWM output stage, bound to the stage's ports.
`timescale 1ns/1ps
`default_nettype none
module bpsd_bridge_pwm_props
  import bpsd_pkg::*;
(
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        pwm_in,
  input wire logic        ext_int_n,
  input wire logic        comp_a,
  input wire logic        comp_b,
  input wire logic        bridge_out_a,
  input wire logic        bridge_out_a_oe,
  input wire logic        bridge_out_b,
  input wire logic        bridge_out_b_oe,
  input wire logic        bridge_out_c,
  input wire logic        bridge_out_c_oe,
  input wire logic        bridge_out_d,
  input wire logic        bridge_out_d_oe
);
  logic [7:0] ctl_q;
  logic [7:0] sd_q;
  logic [7:0] db_q;
  logic [3:0] adr_q;
  logic       wr_q;
  logic       src_on;
  // ****************************************************************
  // Shadow of the configuration written over the bus
  // ****************************************************************
  always_ff @(posedge mclk)
  begin
    wr_q  <= !sys_rst && hsel && hready && htrans[1] && hwrite && haddr[31:4] == 28'h0000000;
    adr_q <= haddr[3:0];
    if (sys_rst)
    begin
      ctl_q <= 8'h00;
      sd_q  <= 8'h00;
      db_q  <= 8'h00;
    end
    else if (wr_q && adr_q == BPSD_OFS_CTRL)
      ctl_q <= hwdata[7:0];
    else if (wr_q && adr_q == BPSD_OFS_SHUTDOWN)
      sd_q <= hwdata[7:0];
    else if (wr_q && adr_q == BPSD_OFS_DEADBAND)
      db_q <= hwdata[7:0];
  end
  assign src_on = (sd_q[4] & comp_a) | (sd_q[5] & comp_b) | (sd_q[6] & ~ext_int_n);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence s_src_held;
    ctl_q[4] && src_on && $past(src_on);
  endsequence
  sequence s_half_rise;
    ctl_q[4] && ctl_q[1:0] == BPSD_MODE_HALF && !src_on && $rose(pwm_in);
  endsequence
  property p_safe_ac;
    s_src_held ##0 !sd_q[3] |-> bridge_out_a == sd_q[2] && bridge_out_a_oe;
  endproperty
  a_safe_ac: assert property (p_safe_ac) else $error("AC safe level wrong");
  property p_safe_bd;
    s_src_held ##0 (ctl_q[0] && !sd_q[1]) |-> bridge_out_b == sd_q[0] && bridge_out_d == sd_q[0];
  endproperty
  a_safe_bd: assert property (p_safe_bd) else $error("BD safe level wrong");
  property p_hiz;
    s_src_held |-> (!sd_q[3] || !bridge_out_a_oe && !bridge_out_c_oe)
      && (!sd_q[1] || !bridge_out_b_oe && !bridge_out_d_oe);
  endproperty
  a_hiz: assert property (p_hiz) else $error("pair not released");
  property p_fwd;
    ctl_q[4] && ctl_q[1:0] == BPSD_MODE_FULL_FWD && bridge_out_a_oe && bridge_out_a != ctl_q[2]
      |-> bridge_out_b == ctl_q[3] && bridge_out_c == ctl_q[2];
  endproperty
  a_fwd: assert property (p_fwd) else $error("forward pattern wrong");
  property p_rev;
    ctl_q[4] && ctl_q[1:0] == BPSD_MODE_FULL_REV && bridge_out_c_oe && bridge_out_c != ctl_q[2]
      |-> bridge_out_a == ctl_q[2] && bridge_out_d == ctl_q[3];
  endproperty
  a_rev: assert property (p_rev) else $error("reverse pattern wrong");
  property p_half_b;
    s_half_rise |=> bridge_out_b == ctl_q[3];
  endproperty
  a_half_b: assert property (p_half_b) else $error("B not off at once");
  property p_dead;
    s_half_rise ##0 db_q[6:0] != 7'h00 |=> (bridge_out_a == ctl_q[2]) [*4];
  endproperty
  a_dead: assert property (p_dead) else $error("A rose inside dead band");
  property p_unused_oe;
    !ctl_q[0] |=> !bridge_out_c_oe && !bridge_out_d_oe;
  endproperty
  a_unused_oe: assert property (p_unused_oe) else $error("unused pin driven");
endmodule
bind bpsd_bridge_pwm bpsd_bridge_pwm_props chk_u (.*);
`default_nettype wire

// ### bpsd_switch_model.sv
// Model of the external bridge switch drivers with pull-downs on the pins.
`timescale 1ns/1ps
`default_nettype none
module bpsd_switch_model
(
  input wire logic [3:0] pin,
  input wire logic [3:0] oe,
  output logic     [3:0] pad,
  output logic           shoot
);
  // A released pin is pulled low.
  assign pad   = pin & oe;
  // Legs are A with B and C with D.
  assign shoot = (pad[0] & pad[1]) | (pad[2] & pad[3]);
endmodule
`default_nettype wire

// ### tb_bridge_pwm_shutdown_deadband.sv
// Self-checking testbench of the bridge PWM output stage.
`timescale 1ns/1ps
`default_nettype none
module tb_bridge_pwm_shutdown_deadband
  import bpsd_pkg::*;
;
  localparam logic [7:0] LIM  = 8'h13;
  localparam logic [7:0] DUTY = 8'h0A;
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic        pwm_in = 1'b0;
  logic        period_start = 1'b0;
  logic [7:0]  period_timer_count = 8'h00;
  logic [7:0]  period_limit = LIM;
  logic        ext_int_n = 1'b1;
  logic        comp_a = 1'b0;
  logic        comp_b = 1'b0;
  logic        shot = 1'b0;
  logic [31:0] hrdata, rd;
  logic        hreadyout, hresp, shoot;
  logic        bridge_out_a, bridge_out_b, bridge_out_c, bridge_out_d;
  logic        bridge_out_a_oe, bridge_out_b_oe, bridge_out_c_oe, bridge_out_d_oe;
  logic [3:0]  pad;
  logic [7:0]  tnext;
  wire logic   hready;
  int          fails = 0;
  int          tests_run = 0;
  int          cyc = 0;
  assign hready = hreadyout;
  assign tnext = (period_timer_count == LIM) ? 8'h00 : period_timer_count + 8'h01;
  bpsd_bridge_pwm dut_u (.*);
  bpsd_switch_model far_u (.pin({bridge_out_d, bridge_out_c, bridge_out_b, bridge_out_a}),
    .oe({bridge_out_d_oe, bridge_out_c_oe, bridge_out_b_oe, bridge_out_a_oe}),
    .pad(pad), .shoot(shoot));
  initial
  begin
    forever #12.5 mclk = ~mclk;
  end
  // ****************************************************************
  // Period timer, duty compare and run limit
  // ****************************************************************
  always @(posedge mclk)
  begin
    period_timer_count <= sys_rst ? 8'h00 : tnext;
    period_start       <= !sys_rst && tnext == 8'h00;
    pwm_in             <= !sys_rst && tnext < DUTY;
    shot               <= sys_rst ? 1'b0 : (shot | shoot);
    cyc                <= cyc + 1;
    if (cyc == 6000)
    begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    xfer(1'b1, {28'h0, a}, {24'h0, d});
  endtask
  task automatic rchk(input string nm, input logic [3:0] a, input logic [31:0] exp);
    xfer(1'b0, {28'h0, a}, 32'h0);
    chk(nm, exp, rd);
  endtask
  task automatic wait_cnt(input logic [7:0] c);
    do @(posedge mclk); while (period_timer_count !== c);
  endtask
  task automatic s_regs();
    rchk("rst_ctrl", BPSD_OFS_CTRL, 32'h0);
    rchk("rst_sd", BPSD_OFS_SHUTDOWN, 32'h0);
    xfer(1'b1, 32'h40, 32'hFF);
    xfer(1'b0, 32'h40, 32'h0);
    chk("unmapped", 32'h0, rd);
    rchk("rst_db", BPSD_OFS_DEADBAND, 32'h0);
  endtask
  task automatic s_half();
    int n;
    wr(BPSD_OFS_DEADBAND, 8'h02);
    wr(BPSD_OFS_CTRL, 8'h12);
    wait_cnt(8'h00);
    wait_cnt(8'h00);
    n = 0;
    while (pad[0] !== 1'b1 && n < 30)
    begin
      @(posedge mclk);
      n++;
    end
    chk("half_delay", 32'h1, {31'h0, n >= 9 && n <= 10});
    chk("half_b", 32'h0, {31'h0, pad[1]});
    wait_cnt(8'h0C);
    chk("half_fall", 32'h0, {28'h0, pad});
    wr(BPSD_OFS_DEADBAND, 8'h14);
    wait_cnt(LIM);
    n = 0;
    repeat (40)
    begin
      @(posedge mclk);
      n = n | pad[0];
    end
    chk("half_long", 32'h0, n);
  endtask
  task automatic s_full();
    wr(BPSD_OFS_CTRL, 8'h11);
    wait_cnt(8'h00);
    wait_cnt(8'h03);
    chk("fwd", 32'h9, {28'h0, pad});
    wr(BPSD_OFS_CTRL, 8'h13);
    wait_cnt(8'h0F);
    chk("pending", 32'h1, {28'h0, pad});
    wait_cnt(8'h12);
    chk("swap", 32'h4, {28'h0, pad});
    rchk("blank_stat", BPSD_OFS_STATUS, 32'h46);
    wait_cnt(8'h03);
    chk("rev", 32'h6, {28'h0, pad});
  endtask
  task automatic s_shut();
    wr(BPSD_OFS_SHUTDOWN, 8'h19);
    comp_a <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("sd_oe", 32'hA, {28'h0, oe_now()});
    chk("sd_pad", 32'hA, {28'h0, pad});
    rchk("sd_stat", BPSD_OFS_SHUTDOWN, 32'h99);
    wr(BPSD_OFS_SHUTDOWN, 8'h19);
    rchk("sd_keep", BPSD_OFS_SHUTDOWN, 32'h99);
    comp_a <= 1'b0;
    repeat (4) @(posedge mclk);
    rchk("sd_sw_only", BPSD_OFS_SHUTDOWN, 32'h99);
    wait_cnt(8'h05);
    wr(BPSD_OFS_SHUTDOWN, 8'h19);
    repeat (2) @(posedge mclk);
    chk("sd_wait", 32'h0, {28'h0, pad});
    wait_cnt(8'h03);
    chk("sd_resume", 32'h6, {28'h0, pad});
  endtask
  function automatic logic [3:0] oe_now();
    return {bridge_out_d_oe, bridge_out_c_oe, bridge_out_b_oe, bridge_out_a_oe};
  endfunction
  task automatic s_restart();
    wr(BPSD_OFS_DEADBAND, 8'h80);
    wr(BPSD_OFS_SHUTDOWN, 8'h40);
    ext_int_n <= 1'b0;
    repeat (3) @(posedge mclk);
    chk("rs_pad", 32'h0, {28'h0, pad});
    rchk("rs_set", BPSD_OFS_SHUTDOWN, 32'hC0);
    ext_int_n <= 1'b1;
    repeat (3) @(posedge mclk);
    rchk("rs_clear", BPSD_OFS_SHUTDOWN, 32'h40);
    wait_cnt(8'h03);
    chk("rs_resume", 32'h6, {28'h0, pad});
    wr(BPSD_OFS_DEADBAND, 8'h00);
    wr(BPSD_OFS_SHUTDOWN, 8'h20);
    comp_b <= 1'b1;
    repeat (3) @(posedge mclk);
    rchk("src_b", BPSD_OFS_SHUTDOWN, 32'hA0);
    comp_b <= 1'b0;
    wr(BPSD_OFS_SHUTDOWN, 8'h00);
    wr(BPSD_OFS_SHUTDOWN, 8'h80);
    rchk("src_sw", BPSD_OFS_SHUTDOWN, 32'h80);
  endtask
  task automatic s_single();
    wr(BPSD_OFS_SHUTDOWN, 8'h00);
    wr(BPSD_OFS_CTRL, 8'h1C);
    wait_cnt(8'h00);
    wait_cnt(8'h03);
    chk("single_on", 32'h0, {28'h0, pad});
    chk("single_oe", 32'h1, {28'h0, oe_now()});
    wait_cnt(8'h0C);
    chk("single_off", 32'h1, {28'h0, pad});
  endtask
  task automatic tally_and_finish();
    if (fails == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    s_regs();
    s_half();
    s_full();
    s_shut();
    s_restart();
    s_single();
    chk("shoot", 32'h0, {31'h0, shot});
    tally_and_finish();
  end
endmodule
`default_nettype wire
